/* File: pkg/tmc_pkg.sv */
// package: register map, field positions, modes and carriers for the timer counter/compare block
package tmc_pkg;

    // ****************
    // register offsets
    // ****************
    localparam logic [7:0] OFF_COUNTER_VALUE = 8'h00;
    localparam logic [7:0] OFF_COMPARE_VALUE_A = 8'h04;
    localparam logic [7:0] OFF_COMPARE_VALUE_B = 8'h08;
    localparam logic [7:0] OFF_TIMER_CONTROL_A = 8'h0C;
    localparam logic [7:0] OFF_TIMER_CONTROL_B = 8'h10;
    localparam logic [7:0] OFF_TIMER_FLAG = 8'h14;
    localparam logic [7:0] OFF_TIMER_MASK = 8'h18;
    localparam logic [7:0] OFF_ASYNC_STATUS = 8'h1C;
    localparam logic [7:0] OFF_POWER_REDUCTION = 8'h20;

    // ****************
    // field positions
    // ****************
    localparam int CTLA_WGM0 = 0;
    localparam int CTLA_WGM1 = 1;
    localparam int CTLA_COMB_LO = 4;
    localparam int CTLA_COMA_LO = 6;
    localparam int CTLB_CS_LO = 0;
    localparam int CTLB_WGM2 = 3;
    localparam int CTLB_FOCB = 6;
    localparam int CTLB_FOCA = 7;
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CMPB = 2;
    localparam int ASY_SEL = 5;
    localparam int PWR_TIM = 6;

    // ****************
    // values
    // ****************
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] CS_NONE = 3'h0;
    localparam logic [2:0] FLG_MASK = 3'h7;
    localparam logic [31:0] PRDATA_ZERO = 32'h0000_0000;

    // waveform_mode_field encodings
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_MAX = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_CMP = 3'h5;
    localparam logic [2:0] WGM_FAST_CMP = 3'h7;

    // output_mode_field encodings
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef enum logic [1:0] {
        TMC_DIR_UP,
        TMC_DIR_DOWN
    } tmc_dir_e;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } tmc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tmc_apb_rsp_s;

endpackage : tmc_pkg

/* File: rtl/tmc_timer.sv */
// timer counter with two compare channels, waveform outputs and an apb register file
//
// The register addresses and register access over APB were chosen for this implementation.
module tmc_timer
    import tmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire tmc_apb_req_s apb_req,
    output tmc_apb_rsp_s apb_rsp,
    input wire logic crystal_pin_in,
    input wire logic io_clock_tick,
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq_req,
    output logic wave_output_a,
    output logic wave_output_b
);

    // ****************
    // functions
    // ****************
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == WGM_PC_MAX) || (m == WGM_FAST_MAX) || (m == WGM_PC_CMP) || (m == WGM_FAST_CMP);
    endfunction

    function automatic logic is_fast(input logic [2:0] m);
        is_fast = (m == WGM_FAST_MAX) || (m == WGM_FAST_CMP);
    endfunction

    function automatic logic match_action(input logic [1:0] com, input logic cur);
        case (com)
            COM_TOGGLE: match_action = ~cur;
            COM_CLEAR: match_action = 1'b0;
            COM_SET: match_action = 1'b1;
            default: match_action = cur;
        endcase
    endfunction

    // ****************
    // registers and decode
    // ****************
    logic [7:0] counter_value_q;
    logic [7:0] compare_value_a_q;
    logic [7:0] compare_value_b_q;
    logic [7:0] buffer_a_q;
    logic [7:0] buffer_b_q;
    logic [7:0] timer_control_a_q;
    logic [7:0] timer_control_b_q;
    logic [2:0] timer_flag_register_q;
    logic [2:0] timer_interrupt_mask_register_q;
    logic async_clock_select_q;
    logic timer_power_reduction_bit_q;
    logic block_match_q;
    logic match_a_q;
    logic match_b_q;
    logic ovf_q;
    logic xtal_s1_q;
    logic xtal_s2_q;
    logic xtal_s3_q;
    tmc_dir_e dir_q;
    logic wave_a_q;
    logic wave_b_q;

    logic wr;
    logic rd;
    logic [2:0] waveform_mode_field;
    logic [2:0] clock_select_field;
    logic [1:0] output_mode_a;
    logic [1:0] output_mode_b;
    logic pwm;
    logic [7:0] top_value;
    logic timer_clock;
    logic at_top;
    logic at_bottom;
    logic cnt_write;
    logic eq_a;
    logic eq_b;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd = apb_req.psel && !apb_req.pwrite;
    assign waveform_mode_field = {timer_control_b_q[CTLB_WGM2], timer_control_a_q[CTLA_WGM1],
                                  timer_control_a_q[CTLA_WGM0]};
    assign clock_select_field = timer_control_b_q[CTLB_CS_LO +: 3];
    assign output_mode_a = timer_control_a_q[CTLA_COMA_LO +: 2];
    assign output_mode_b = timer_control_a_q[CTLA_COMB_LO +: 2];
    assign pwm = is_pwm(waveform_mode_field);
    assign cnt_write = wr && (apb_req.paddr == OFF_COUNTER_VALUE);

    // top is compare a in ctc and compare-topped pwm, otherwise max
    assign top_value = ((waveform_mode_field == WGM_CTC) || (waveform_mode_field == WGM_PC_CMP)
                        || (waveform_mode_field == WGM_FAST_CMP)) ? compare_value_a_q : CNT_MAX;
    assign at_top = (counter_value_q == top_value);
    assign at_bottom = (counter_value_q == CNT_BOTTOM);

    // ****************
    // timer clock source
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
        end else begin
            xtal_s1_q <= crystal_pin_in;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
        end
    end

    // stopped when powered down or no source selected
    assign timer_clock = !timer_power_reduction_bit_q && (clock_select_field != CS_NONE)
                         && (async_clock_select_q ? (xtal_s2_q && !xtal_s3_q) : io_clock_tick);

    // ****************
    // counter
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_q <= RST_BYTE;
            dir_q <= TMC_DIR_UP;
        end else if (cnt_write) begin
            counter_value_q <= apb_req.pwdata[7:0];
        end else if (timer_clock) begin
            case (waveform_mode_field)
                WGM_NORMAL: counter_value_q <= counter_value_q + CNT_ONE;
                WGM_CTC, WGM_FAST_MAX, WGM_FAST_CMP: begin
                    counter_value_q <= at_top ? CNT_BOTTOM : counter_value_q + CNT_ONE;
                end
                WGM_PC_MAX, WGM_PC_CMP: begin
                    if (dir_q == TMC_DIR_UP && at_top) begin
                        dir_q <= TMC_DIR_DOWN;
                        counter_value_q <= counter_value_q - CNT_ONE;
                    end else if (dir_q == TMC_DIR_DOWN && at_bottom) begin
                        dir_q <= TMC_DIR_UP;
                        counter_value_q <= counter_value_q + CNT_ONE;
                    end else if (dir_q == TMC_DIR_DOWN) begin
                        counter_value_q <= counter_value_q - CNT_ONE;
                    end else begin
                        counter_value_q <= counter_value_q + CNT_ONE;
                    end
                end
                default: counter_value_q <= counter_value_q + CNT_ONE;
            endcase
        end
    end

    // ****************
    // compare registers and buffers
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_a_q <= RST_BYTE;
            buffer_b_q <= RST_BYTE;
        end else begin
            if (wr && apb_req.paddr == OFF_COMPARE_VALUE_A) begin
                buffer_a_q <= apb_req.pwdata[7:0];
            end
            if (wr && apb_req.paddr == OFF_COMPARE_VALUE_B) begin
                buffer_b_q <= apb_req.pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_a_q <= RST_BYTE;
            compare_value_b_q <= RST_BYTE;
        end else if (!pwm) begin
            if (wr && apb_req.paddr == OFF_COMPARE_VALUE_A) begin
                compare_value_a_q <= apb_req.pwdata[7:0];
            end
            if (wr && apb_req.paddr == OFF_COMPARE_VALUE_B) begin
                compare_value_b_q <= apb_req.pwdata[7:0];
            end
        end else if (timer_clock && (is_fast(waveform_mode_field) ? at_bottom : at_top)) begin
            compare_value_a_q <= buffer_a_q;
            compare_value_b_q <= buffer_b_q;
        end
    end

    // ****************
    // compare match and blocking
    // ****************
    assign eq_a = (counter_value_q == compare_value_a_q);
    assign eq_b = (counter_value_q == compare_value_b_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_match_q <= 1'b0;
        end else if (cnt_write) begin
            block_match_q <= 1'b1;
        end else if (timer_clock) begin
            block_match_q <= 1'b0;
        end
    end

    // match registered for the timer clock after equality
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_q <= 1'b0;
            match_b_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            match_a_q <= timer_clock && eq_a && !block_match_q && !cnt_write;
            match_b_q <= timer_clock && eq_b && !block_match_q && !cnt_write;
            ovf_q <= timer_clock && !cnt_write && (pwm && !is_fast(waveform_mode_field) ? at_bottom
                     : counter_value_q == CNT_MAX);
        end
    end

    // ****************
    // flags and requests
    // ****************
    assign flag_set = {match_b_q, match_a_q, ovf_q};
    assign flag_clr = irq_ack | ((wr && apb_req.paddr == OFF_TIMER_FLAG) ? apb_req.pwdata[2:0] : 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_flag_register_q <= 3'h0;
        end else begin
            timer_flag_register_q <= flag_set | (timer_flag_register_q & ~flag_clr);
        end
    end

    assign irq_req = timer_flag_register_q & timer_interrupt_mask_register_q;

    // ****************
    // waveform generator
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
        end else if (!pwm) begin
            if ((wr && apb_req.paddr == OFF_TIMER_CONTROL_B && apb_req.pwdata[CTLB_FOCA]) || match_a_q) begin
                wave_a_q <= match_action(output_mode_a, wave_a_q);
            end
            if ((wr && apb_req.paddr == OFF_TIMER_CONTROL_B && apb_req.pwdata[CTLB_FOCB]) || match_b_q) begin
                wave_b_q <= match_action(output_mode_b, wave_b_q);
            end
        end else begin
            // pwm: clear (set if inverted) on match, opposite at bottom in fast pwm only
            if (output_mode_a[1] && match_a_q) begin
                wave_a_q <= output_mode_a[0];
            end else if (output_mode_a[1] && timer_clock && at_bottom && is_fast(waveform_mode_field)) begin
                wave_a_q <= ~output_mode_a[0];
            end
            if (output_mode_b[1] && match_b_q) begin
                wave_b_q <= output_mode_b[0];
            end else if (output_mode_b[1] && timer_clock && at_bottom && is_fast(waveform_mode_field)) begin
                wave_b_q <= ~output_mode_b[0];
            end
        end
    end

    assign wave_output_a = wave_a_q;
    assign wave_output_b = wave_b_q;

    // ****************
    // apb register file
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_a_q <= RST_BYTE;
            timer_control_b_q <= RST_BYTE;
            timer_interrupt_mask_register_q <= 3'h0;
            async_clock_select_q <= 1'b0;
            timer_power_reduction_bit_q <= 1'b0;
        end else if (wr) begin
            if (apb_req.paddr == OFF_TIMER_CONTROL_A) begin
                timer_control_a_q <= apb_req.pwdata[7:0];
            end else if (apb_req.paddr == OFF_TIMER_CONTROL_B) begin
                // force bits are strobes and never stored
                timer_control_b_q <= {2'b00, apb_req.pwdata[5:0]};
            end else if (apb_req.paddr == OFF_TIMER_MASK) begin
                timer_interrupt_mask_register_q <= apb_req.pwdata[2:0] & FLG_MASK;
            end else if (apb_req.paddr == OFF_ASYNC_STATUS) begin
                async_clock_select_q <= apb_req.pwdata[ASY_SEL];
            end else if (apb_req.paddr == OFF_POWER_REDUCTION) begin
                timer_power_reduction_bit_q <= apb_req.pwdata[PWR_TIM];
            end
        end
    end

    logic [31:0] prdata_q;
    logic err_d;

    always_comb begin
        err_d = 1'b0;
        if (apb_req.paddr == OFF_COUNTER_VALUE || apb_req.paddr == OFF_COMPARE_VALUE_A
            || apb_req.paddr == OFF_COMPARE_VALUE_B || apb_req.paddr == OFF_TIMER_CONTROL_A
            || apb_req.paddr == OFF_TIMER_CONTROL_B || apb_req.paddr == OFF_TIMER_FLAG
            || apb_req.paddr == OFF_TIMER_MASK || apb_req.paddr == OFF_ASYNC_STATUS
            || apb_req.paddr == OFF_POWER_REDUCTION) begin
            err_d = 1'b0;
        end else begin
            err_d = 1'b1;
        end
    end

    // read data captured in setup, returned in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= PRDATA_ZERO;
        end else if (rd && !apb_req.penable) begin
            if (apb_req.paddr == OFF_COUNTER_VALUE) begin
                prdata_q <= {24'h0, counter_value_q};
            end else if (apb_req.paddr == OFF_COMPARE_VALUE_A) begin
                prdata_q <= {24'h0, pwm ? buffer_a_q : compare_value_a_q};
            end else if (apb_req.paddr == OFF_COMPARE_VALUE_B) begin
                prdata_q <= {24'h0, pwm ? buffer_b_q : compare_value_b_q};
            end else if (apb_req.paddr == OFF_TIMER_CONTROL_A) begin
                prdata_q <= {24'h0, timer_control_a_q};
            end else if (apb_req.paddr == OFF_TIMER_CONTROL_B) begin
                prdata_q <= {24'h0, timer_control_b_q};
            end else if (apb_req.paddr == OFF_TIMER_FLAG) begin
                prdata_q <= {29'h0, timer_flag_register_q};
            end else if (apb_req.paddr == OFF_TIMER_MASK) begin
                prdata_q <= {29'h0, timer_interrupt_mask_register_q};
            end else if (apb_req.paddr == OFF_ASYNC_STATUS) begin
                prdata_q <= {26'h0, async_clock_select_q, 5'h0};
            end else if (apb_req.paddr == OFF_POWER_REDUCTION) begin
                prdata_q <= {25'h0, timer_power_reduction_bit_q, 6'h0};
            end else begin
                prdata_q <= PRDATA_ZERO;
            end
        end
    end

    assign apb_rsp.prdata = prdata_q;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && err_d;

    // ****************
    // assertions
    // ****************
    a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_write |=> counter_value_q == $past(apb_req.pwdata[7:0]))
        else $error("counter write lost");

    a_stopped_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (clock_select_field == CS_NONE && !cnt_write) |=> $stable(counter_value_q))
        else $error("counter moved without clock");

    a_power_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_power_reduction_bit_q && !cnt_write) |=> $stable(counter_value_q))
        else $error("counter moved while powered down");

    a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_clock && eq_a && !block_match_q && !cnt_write) |=> ##1 timer_flag_register_q[FLG_CMPA])
        else $error("compare a flag not set");

    a_block_after: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_write || (block_match_q && timer_clock)) |=> !match_a_q && !match_b_q)
        else $error("match not blocked after write");

    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (match_a_q && timer_interrupt_mask_register_q[FLG_CMPA] && !wr) |=> irq_req[FLG_CMPA])
        else $error("compare request not raised");

    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_q |=> timer_flag_register_q[FLG_OVF])
        else $error("overflow lost to clear");

    a_normal_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (waveform_mode_field == WGM_NORMAL && timer_clock && !cnt_write && counter_value_q == CNT_MAX)
        |=> counter_value_q == CNT_BOTTOM ##1 timer_flag_register_q[FLG_OVF])
        else $error("normal wrap or overflow wrong");

    a_no_force_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (!match_a_q && !match_b_q && !ovf_q) |=> (timer_flag_register_q & ~$past(timer_flag_register_q)) == 3'h0)
        else $error("flag set without event");

    a_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (!pwm && output_mode_a == COM_OFF) |=> $stable(wave_a_q))
        else $error("output changed with mode off");

endmodule // tmc_timer

/* File: testbench/test_tmc_timer.sv */
// testbench: registers, counting, flags, blocking and outputs of the timer block
module test_tmc_timer
    import tmc_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
// ****
// signals and design
// ****
logic pclk = 1'b0;
logic presetn = 1'b0;
logic tick = 1'b0;
logic xtal = 1'b0;
logic [2:0] ack = 3'h0;
logic [2:0] irq;
logic wa;
logic wb;
tmc_apb_req_s req = '0;
tmc_apb_rsp_s rsp;
logic [31:0] rd;
logic err;
logic [7:0] r;
logic [7:0] e;
int err_count = 0;
int n_tests = 0;
int seed = 11;
tmc_timer tmc_timer_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .crystal_pin_in(xtal), .io_clock_tick(tick), .irq_ack(ack), .irq_req(irq),
    .wave_output_a(wa), .wave_output_b(wb));
initial begin
    forever #4 pclk = ~pclk;
end
// ****
// tasks
// ****
task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
        err_count++;
        $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, rd);
endtask
// timer ticks, then room for match pulse and flag
task automatic ticks(input int n);
    repeat (n) begin
        @(posedge pclk) tick <= 1'b1;
        @(posedge pclk) tick <= 1'b0;
    end
    repeat (4) @(posedge pclk);
endtask
task automatic pulse_ack(input logic [2:0] v);
    @(posedge pclk) ack <= v;
    @(posedge pclk) ack <= 3'h0;
    repeat (2) @(posedge pclk);
endtask
function automatic logic [7:0] nxt(input logic [7:0] c, input logic [7:0] top, input logic clr);
    return (clr && c == top) ? 8'h00 : c + 8'h01;
endfunction
// ****
// sequence
// ****
initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i <= 8; i++) rdc(8'(i * 4), 32'h0, "reset value");
    apb(1'b0, 8'h24, 32'hFFFF_FFFF);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("done: reset");
    apb(1'b1, OFF_TIMER_MASK, 32'h7);
    apb(1'b1, OFF_COUNTER_VALUE, 32'h10);
    ticks(5);
    rdc(OFF_COUNTER_VALUE, 32'h10, "stopped");
    for (int i = 0; i < 8; i++) begin
        r = 8'($random(seed));
        apb(1'b1, OFF_COUNTER_VALUE, {24'hFFFFFF, r});
        rdc(OFF_COUNTER_VALUE, {24'h0, r}, "counter rw");
        apb(1'b1, OFF_COMPARE_VALUE_B, {24'h0, ~r});
        rdc(OFF_COMPARE_VALUE_B, {24'h0, ~r}, "compare direct");
    end
    $display("done: access");
    apb(1'b1, OFF_COMPARE_VALUE_A, 32'h80);
    apb(1'b1, OFF_COMPARE_VALUE_B, 32'h81);
    apb(1'b1, OFF_TIMER_CONTROL_B, 32'h1);
    e = 8'hFD;
    apb(1'b1, OFF_COUNTER_VALUE, {24'h0, e});
    for (int i = 0; i < 3; i++) e = nxt(e, 8'hFF, 1'b0);
    ticks(3);
    rdc(OFF_COUNTER_VALUE, {24'h0, e}, "wrap");
    rdc(OFF_TIMER_FLAG, 32'h1, "overflow");
    chk("irq ovf", 32'h1, {29'h0, irq});
    apb(1'b1, OFF_TIMER_MASK, 32'h6);
    @(negedge pclk);
    chk("irq masked", 32'h0, {29'h0, irq});
    pulse_ack(3'h1);
    rdc(OFF_TIMER_FLAG, 32'h0, "ack ovf");
    apb(1'b1, OFF_COUNTER_VALUE, 32'h7E);
    ticks(4);
    rdc(OFF_TIMER_FLAG, 32'h6, "matches");
    chk("irq cmp", 32'h6, {29'h0, irq});
    apb(1'b1, OFF_TIMER_FLAG, 32'h4);
    rdc(OFF_TIMER_FLAG, 32'h2, "w1c");
    pulse_ack(3'h2);
    rdc(OFF_TIMER_FLAG, 32'h0, "ack cmp");
    $display("done: flags");
    apb(1'b1, OFF_COUNTER_VALUE, 32'h80);
    ticks(1);
    rdc(OFF_TIMER_FLAG, 32'h0, "blocked");
    ticks(1);
    rdc(OFF_TIMER_FLAG, 32'h4, "unblocked");
    apb(1'b1, OFF_TIMER_FLAG, 32'h7);
    apb(1'b1, OFF_TIMER_CONTROL_A, 32'h40);
    apb(1'b1, OFF_TIMER_CONTROL_B, 32'h81);
    repeat (2) @(posedge pclk);
    chk("force a", 32'h1, {31'h0, wa});
    rdc(OFF_TIMER_FLAG, 32'h0, "force flag");
    rdc(OFF_COUNTER_VALUE, 32'h82, "force count");
    apb(1'b1, OFF_TIMER_CONTROL_B, 32'hC1);
    repeat (2) @(posedge pclk);
    chk("toggle a", 32'h0, {31'h0, wa});
    chk("off b", 32'h0, {31'h0, wb});
    $display("done: force");
    apb(1'b1, OFF_TIMER_CONTROL_A, 32'h2);
    apb(1'b1, OFF_COMPARE_VALUE_A, 32'h3);
    rdc(OFF_COMPARE_VALUE_A, 32'h3, "ctc direct");
    apb(1'b1, OFF_COUNTER_VALUE, 32'h0);
    e = 8'h00;
    for (int i = 0; i < 5; i++) e = nxt(e, 8'h03, 1'b1);
    ticks(5);
    rdc(OFF_COUNTER_VALUE, {24'h0, e}, "ctc");
    apb(1'b1, OFF_TIMER_CONTROL_A, 32'h0);
    apb(1'b1, OFF_ASYNC_STATUS, 32'h20);
    apb(1'b1, OFF_COUNTER_VALUE, 32'h0);
    ticks(2);
    rdc(OFF_COUNTER_VALUE, 32'h0, "io ignored");
    repeat (3) begin
        @(posedge pclk) xtal <= 1'b1;
        repeat (4) @(posedge pclk);
        xtal <= 1'b0;
        repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    rdc(OFF_COUNTER_VALUE, 32'h3, "crystal");
    $display("done: modes");
    apb(1'b1, OFF_ASYNC_STATUS, 32'h0);
    apb(1'b1, OFF_POWER_REDUCTION, 32'h40);
    apb(1'b1, OFF_COUNTER_VALUE, 32'h5);
    ticks(3);
    rdc(OFF_COUNTER_VALUE, 32'h5, "powered down");
    apb(1'b1, OFF_POWER_REDUCTION, 32'h0);
    apb(1'b1, OFF_TIMER_CONTROL_A, 32'hC3);
    apb(1'b1, OFF_COMPARE_VALUE_A, 32'h10);
    rdc(OFF_COMPARE_VALUE_A, 32'h10, "pwm buffer");
    apb(1'b1, OFF_COUNTER_VALUE, 32'h1);
    ticks(3);
    chk("pwm old compare", 32'h1, {31'h0, wa});
    apb(1'b1, OFF_COUNTER_VALUE, 32'hFE);
    ticks(3);
    chk("pwm bottom", 32'h0, {31'h0, wa});
    ticks(3);
    chk("pwm reloaded", 32'h0, {31'h0, wa});
    ticks(13);
    chk("pwm new compare", 32'h1, {31'h0, wa});
    rdc(OFF_COUNTER_VALUE, 32'h11, "fast pwm");
    apb(1'b1, OFF_TIMER_CONTROL_A, 32'h1);
    apb(1'b1, OFF_COUNTER_VALUE, 32'hFE);
    ticks(3);
    rdc(OFF_COUNTER_VALUE, 32'hFD, "phase down");
    $display("done: pwm");
    give_verdict;
end
// run takes a few hundred cycles
initial begin
    #100us;
    err_count++;
    give_verdict;
end
endmodule // test_tmc_timer
